// ===== asrp_device.sv
`timescale 1ns/1ps
module asrp_device
	import asrp_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	asrp_if.device bus,
	input wire logic [11:0] unscaled_angle_i,
	input wire logic [11:0] angle_i,
	input wire logic [11:0] magnitude_i,
	input wire logic [7:0] gain_i,
	input wire logic [2:0] magnet_i,
	input wire logic [1:0] nv_burn_count_i,
	input wire logic [11:0] nv_start_i,
	input wire logic [11:0] nv_stop_i,
	input wire logic [11:0] nv_span_i,
	input wire logic [13:0] nv_config_i,
	output logic [1:0] power_mode_sel_o,
	output logic [1:0] output_hysteresis_o,
	output logic [1:0] output_stage_sel_o,
	output logic [1:0] pulse_freq_sel_o,
	output logic [1:0] slow_filter_sel_o,
	output logic [2:0] fast_filter_threshold_o,
	output logic watchdog_enable_o,
	output logic [11:0] start_position_o,
	output logic [11:0] stop_position_o,
	output logic [11:0] span_setting_o,
	output logic burn_angle_o,
	output logic burn_setting_o
);
	typedef enum {
		ASRP_IDLE, ASRP_RX, ASRP_RX_ACK, ASRP_TX, ASRP_TX_ACK
	} asrp_state_t;
	typedef struct packed {
		logic [1:0] scl_s;
		logic [1:0] sda_s;
		logic [3:0] scl_cnt;
		logic [3:0] sda_cnt;
		logic scl_f;
		logic sda_f;
		asrp_state_t st;
		logic [3:0] bitn;
		logic [7:0] shreg;
		logic first;
		logic second;
		logic rd;
		logic ack_drive;
		logic hold_ptr;
		logic [7:0] ptr;
		logic loaded;
		logic [11:0] start_pos;
		logic [11:0] stop_pos;
		logic [11:0] span;
		logic [13:0] cfg;
		logic burn_angle;
		logic burn_setting;
		logic sda_oe;
	} asrp_dev_t;
	asrp_dev_t r;
	asrp_dev_t next_r;
	logic scl_rise;
	logic scl_fall;
	logic start_cond;
	logic stop_cond;
	logic [7:0] rdata;

	// Readback mux; unmapped and spare bits read as zero
	always_comb begin
		case (r.ptr)
			ASRP_A_BURN_COUNT: rdata = {6'h00, nv_burn_count_i};
			ASRP_A_START_HI: rdata = {4'h0, r.start_pos[11:8]};
			ASRP_A_START_LO: rdata = r.start_pos[7:0];
			ASRP_A_STOP_HI: rdata = {4'h0, r.stop_pos[11:8]};
			ASRP_A_STOP_LO: rdata = r.stop_pos[7:0];
			ASRP_A_SPAN_HI: rdata = {4'h0, r.span[11:8]};
			ASRP_A_SPAN_LO: rdata = r.span[7:0];
			ASRP_A_CONFIG_HI: rdata = {2'h0, r.cfg[13:8]};
			ASRP_A_CONFIG_LO: rdata = r.cfg[7:0];
			ASRP_A_STATUS: rdata = {2'h0, magnet_i, 3'h0};
			ASRP_A_UNSCALED_HI: rdata = {4'h0, unscaled_angle_i[11:8]};
			ASRP_A_UNSCALED_LO: rdata = unscaled_angle_i[7:0];
			ASRP_A_ANGLE_HI: rdata = {4'h0, angle_i[11:8]};
			ASRP_A_ANGLE_LO: rdata = angle_i[7:0];
			ASRP_A_GAIN: rdata = gain_i;
			ASRP_A_MAG_HI: rdata = {4'h0, magnitude_i[11:8]};
			ASRP_A_MAG_LO: rdata = magnitude_i[7:0];
			default: rdata = 8'h00;
		endcase
	end

	// Edge and condition detect on filtered lines
	assign scl_rise = ~r.scl_f & next_r.scl_f;
	assign scl_fall = r.scl_f & ~next_r.scl_f;
	assign start_cond = r.scl_f & next_r.scl_f & r.sda_f & ~next_r.sda_f;
	assign stop_cond = r.scl_f & next_r.scl_f & ~r.sda_f & next_r.sda_f;

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		next_r = r;
		next_r.burn_angle = 1'b0;
		next_r.burn_setting = 1'b0;
		// Two-stage synchronisers, then a persistence filter
		next_r.scl_s = {r.scl_s[0], bus.scl};
		next_r.sda_s = {r.sda_s[0], bus.sda};
		// Level must persist ASRP_GLITCH_CYC cycles before it counts
		if (r.scl_s[1] == r.scl_f) begin
			next_r.scl_cnt = 4'h0;
		end else if (r.scl_cnt == 4'(ASRP_GLITCH_CYC - 1)) begin
			next_r.scl_f = r.scl_s[1];
			next_r.scl_cnt = 4'h0;
		end else begin
			next_r.scl_cnt = r.scl_cnt + 4'h1;
		end
		if (r.sda_s[1] == r.sda_f) begin
			next_r.sda_cnt = 4'h0;
		end else if (r.sda_cnt == 4'(ASRP_GLITCH_CYC - 1)) begin
			next_r.sda_f = r.sda_s[1];
			next_r.sda_cnt = 4'h0;
		end else begin
			next_r.sda_cnt = r.sda_cnt + 4'h1;
		end
		// Power-up load of the programmed store, one shot
		if (!r.loaded) begin
			next_r.loaded = 1'b1;
			next_r.start_pos = nv_start_i;
			next_r.stop_pos = nv_stop_i;
			next_r.span = nv_span_i;
			next_r.cfg = nv_config_i & ASRP_CONFIG_MASK;
		end
		if (start_cond) begin
			next_r.st = ASRP_RX;
			next_r.bitn = 4'h0;
			next_r.first = 1'b1;
			next_r.sda_oe = 1'b0;
		end else if (stop_cond) begin
			next_r.st = ASRP_IDLE;
			next_r.sda_oe = 1'b0;
		end else begin
			case (r.st)
				ASRP_IDLE: begin
					next_r.sda_oe = 1'b0;
				end
				ASRP_RX: begin
					if (scl_rise) begin
						next_r.shreg = {r.shreg[6:0], r.sda_f};
						next_r.bitn = r.bitn + 4'h1;
					end
					if (scl_fall && r.bitn == 4'h8) begin
						next_r.st = ASRP_RX_ACK;
						next_r.ack_drive = 1'b1;
						if (r.first) begin
							// Foreign address: go quiet till next start
							if (r.shreg[7:1] != ASRP_SLAVE_ADDR) begin
								next_r.st = ASRP_IDLE;
								next_r.ack_drive = 1'b0;
							end
							next_r.rd = r.shreg[0];
							next_r.second = ~r.shreg[0];
						end else if (r.second) begin
							next_r.ptr = r.shreg;
						end else begin
							// Writes land only on writable registers
							case (r.ptr)
								ASRP_A_START_HI: next_r.start_pos[11:8] = r.shreg[3:0];
								ASRP_A_START_LO: next_r.start_pos[7:0] = r.shreg;
								ASRP_A_STOP_HI: next_r.stop_pos[11:8] = r.shreg[3:0];
								ASRP_A_STOP_LO: next_r.stop_pos[7:0] = r.shreg;
								ASRP_A_SPAN_HI: next_r.span[11:8] = r.shreg[3:0];
								ASRP_A_SPAN_LO: next_r.span[7:0] = r.shreg;
								ASRP_A_CONFIG_HI: next_r.cfg[13:8] = r.shreg[5:0];
								ASRP_A_CONFIG_LO: next_r.cfg[7:0] = r.shreg;
								ASRP_A_BURN_CMD: begin
									next_r.burn_angle = r.shreg == ASRP_CMD_BURN_ANGLE;
									next_r.burn_setting = r.shreg == ASRP_CMD_BURN_SETTING;
								end
								default: ;
							endcase
							next_r.ptr = r.ptr + 8'h01;
						end
						next_r.sda_oe = next_r.ack_drive;
					end
				end
				ASRP_RX_ACK: begin
					if (scl_fall) begin
						next_r.bitn = 4'h0;
						next_r.first = 1'b0;
						if (r.first) begin
							next_r.second = ~r.rd;
						end else begin
							next_r.second = 1'b0;
						end
						if (r.rd && r.first) begin
							// Send from current pointer
							next_r.st = ASRP_TX;
							next_r.shreg = rdata;
							next_r.hold_ptr = (r.ptr == ASRP_A_UNSCALED_HI)
								|| (r.ptr == ASRP_A_ANGLE_HI)
								|| (r.ptr == ASRP_A_MAG_HI);
							next_r.sda_oe = ~rdata[7];
						end else begin
							next_r.st = ASRP_RX;
							next_r.sda_oe = 1'b0;
						end
					end
				end
				ASRP_TX: begin
					if (scl_fall) begin
						next_r.bitn = r.bitn + 4'h1;
						if (r.bitn == 4'h7) begin
							next_r.st = ASRP_TX_ACK;
							next_r.sda_oe = 1'b0;
							if (!r.hold_ptr) begin
								next_r.ptr = r.ptr + 8'h01;
							end
						end else begin
							next_r.shreg = {r.shreg[6:0], 1'b0};
							next_r.sda_oe = ~r.shreg[6];
						end
					end
				end
				ASRP_TX_ACK: begin
					if (scl_rise) begin
						next_r.rd = ~r.sda_f;
					end
					if (scl_fall) begin
						next_r.bitn = 4'h0;
						if (r.rd) begin // Master ack: next byte
							next_r.st = ASRP_TX;
							next_r.shreg = rdata;
							next_r.sda_oe = ~rdata[7];
						end else begin // Nack: release line, wait stop
							next_r.st = ASRP_IDLE;
						end
					end
				end
				default: next_r.st = ASRP_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// State register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			r <= '0;
			r.scl_s <= 2'h3;
			r.sda_s <= 2'h3;
			r.scl_f <= 1'b1;
			r.sda_f <= 1'b1;
			r.st <= ASRP_IDLE;
		end else begin
			r <= next_r;
		end
	end

	// Data line only ever pulled low
	assign bus.sda_dev_o = 1'b0;
	assign bus.sda_dev_oe = r.sda_oe;
	// Config fields straight from the config flops
	assign power_mode_sel_o = r.cfg[ASRP_CF_POWER +: 2];
	assign output_hysteresis_o = r.cfg[ASRP_CF_OUTPUT_HYSTERESIS +: 2];
	assign output_stage_sel_o = r.cfg[ASRP_CF_OUTPUT_STAGE_SEL +: 2];
	assign pulse_freq_sel_o = r.cfg[ASRP_CF_PULSE_FREQ_SEL +: 2];
	assign slow_filter_sel_o = r.cfg[ASRP_CF_SLOW +: 2];
	assign fast_filter_threshold_o = r.cfg[ASRP_CF_FAST +: 3];
	assign watchdog_enable_o = r.cfg[ASRP_CF_WDOG];
	assign start_position_o = r.start_pos;
	assign stop_position_o = r.stop_pos;
	assign span_setting_o = r.span;
	assign burn_angle_o = r.burn_angle;
	assign burn_setting_o = r.burn_setting;
endmodule

// ===== asrp_pkg.sv
package asrp_pkg;
	// Bus address and field layout
	localparam logic [6:0] ASRP_SLAVE_ADDR = 7'h36;
	localparam logic [7:0] ASRP_A_BURN_COUNT = 8'h00;
	localparam logic [7:0] ASRP_A_START_HI = 8'h01;
	localparam logic [7:0] ASRP_A_START_LO = 8'h02;
	localparam logic [7:0] ASRP_A_STOP_HI = 8'h03;
	localparam logic [7:0] ASRP_A_STOP_LO = 8'h04;
	localparam logic [7:0] ASRP_A_SPAN_HI = 8'h05;
	localparam logic [7:0] ASRP_A_SPAN_LO = 8'h06;
	localparam logic [7:0] ASRP_A_CONFIG_HI = 8'h07;
	localparam logic [7:0] ASRP_A_CONFIG_LO = 8'h08;
	localparam logic [7:0] ASRP_A_STATUS = 8'h0B;
	localparam logic [7:0] ASRP_A_UNSCALED_HI = 8'h0C;
	localparam logic [7:0] ASRP_A_UNSCALED_LO = 8'h0D;
	localparam logic [7:0] ASRP_A_ANGLE_HI = 8'h0E;
	localparam logic [7:0] ASRP_A_ANGLE_LO = 8'h0F;
	localparam logic [7:0] ASRP_A_GAIN = 8'h1A;
	localparam logic [7:0] ASRP_A_MAG_HI = 8'h1B;
	localparam logic [7:0] ASRP_A_MAG_LO = 8'h1C;
	localparam logic [7:0] ASRP_A_BURN_CMD = 8'hFF;
	localparam logic [7:0] ASRP_CMD_BURN_ANGLE = 8'h80;
	localparam logic [7:0] ASRP_CMD_BURN_SETTING = 8'h40;
	// Config word fields (lsb positions)
	localparam int ASRP_CF_POWER = 0;
	localparam int ASRP_CF_OUTPUT_HYSTERESIS = 2;
	localparam int ASRP_CF_OUTPUT_STAGE_SEL = 4;
	localparam int ASRP_CF_PULSE_FREQ_SEL = 6;
	localparam int ASRP_CF_SLOW = 8;
	localparam int ASRP_CF_FAST = 10;
	localparam int ASRP_CF_WDOG = 13;
	localparam logic [13:0] ASRP_CONFIG_MASK = 14'h3FFF;
	// Status bit positions
	localparam int ASRP_ST_STRONG = 3;
	localparam int ASRP_ST_WEAK = 4;
	localparam int ASRP_ST_PRESENT = 5;
	// Glitch filter: pulses under 50 ns ignored
	localparam int ASRP_CLK_MHZ = 200;
	localparam int ASRP_GLITCH_NS = 50;
	localparam int ASRP_GLITCH_CYC = (ASRP_GLITCH_NS * ASRP_CLK_MHZ + 999) / 1000;
	// Host: serial clock half period in system cycles
	localparam int ASRP_HALF_CYC = 25;
	// Host register offsets on Wishbone (byte addresses)
	localparam logic [3:0] ASRP_H_CTRL = 4'h0;
	localparam logic [3:0] ASRP_H_ADDR = 4'h4;
	localparam logic [3:0] ASRP_H_WDATA = 4'h8;
	localparam logic [3:0] ASRP_H_STATUS = 4'hC;
	// Host control bits
	localparam int ASRP_HC_GO = 0;
	localparam int ASRP_HC_READ = 1;
	localparam int ASRP_HC_SETPTR = 2;
endpackage

// ===== asrp_if.sv
`timescale 1ns/1ps
interface asrp_if;
	logic scl_o;
	logic scl_oe;
	logic sda_dev_o;
	logic sda_dev_oe;
	logic sda_host_o;
	logic sda_host_oe;
	logic scl;
	logic sda;
	// Open-drain lines; data is a wired-and of both drivers, clock has the host alone
	assign scl = ~(scl_oe & ~scl_o);
	assign sda = ~((sda_dev_oe & ~sda_dev_o) | (sda_host_oe & ~sda_host_o));
	modport device (input scl, input sda, output sda_dev_o, output sda_dev_oe);
	modport host (input scl, input sda, output scl_o, output scl_oe,
		output sda_host_o, output sda_host_oe);
endinterface

// ===== asrp_host.sv
`timescale 1ns/1ps
module asrp_host
	import asrp_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	asrp_if.host bus,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o
);
	typedef enum {
		ASRPH_IDLE, ASRPH_START, ASRPH_BIT, ASRPH_STOP
	} asrph_state_t;
	typedef struct packed {
		logic [1:0] sda_s;
		asrph_state_t st;
		logic [5:0] phase;
		logic [4:0] cnt;
		logic [26:0] seq;
		logic [26:0] rdmask;
		logic [4:0] nbits;
		logic [7:0] rbyte;
		logic nack;
		logic busy;
		logic [2:0] ctrl;
		logic [7:0] addr;
		logic [7:0] wdata;
		logic scl;
		logic sda;
		logic ack;
		logic [31:0] dout;
	} asrph_t;
	asrph_t r;
	asrph_t next_r;
	logic wb_req;

	assign wb_req = wb_cyc_i & wb_stb_i & ~r.ack;

	////////////////////////////////////////////////////////////////////////
	// Bus slave plus serial sequencer; one transaction per command, two bytes after the address for a write
	always_comb begin
		next_r = r;
		next_r.sda_s = {r.sda_s[0], bus.sda};
		next_r.ack = wb_req;
		if (wb_req) begin
			next_r.dout = 32'h0000_0000;
			case (wb_adr_i)
				ASRP_H_CTRL: next_r.dout = {29'h0, r.ctrl};
				ASRP_H_ADDR: next_r.dout = {24'h0, r.addr};
				ASRP_H_WDATA: next_r.dout = {24'h0, r.wdata};
				ASRP_H_STATUS: next_r.dout = {22'h0, r.nack, r.busy, r.rbyte};
				default: ;
			endcase
			if (wb_we_i && wb_sel_i[0] && !r.busy) begin
				case (wb_adr_i)
					ASRP_H_CTRL: next_r.ctrl = wb_dat_i[2:0];
					ASRP_H_ADDR: next_r.addr = wb_dat_i[7:0];
					ASRP_H_WDATA: next_r.wdata = wb_dat_i[7:0];
					default: ;
				endcase
			end
		end
		case (r.st)
			ASRPH_IDLE: begin
				next_r.scl = 1'b1;
				next_r.sda = 1'b1;
				if (r.ctrl[ASRP_HC_GO]) begin
					next_r.ctrl[ASRP_HC_GO] = 1'b0;
					next_r.busy = 1'b1;
					next_r.nack = 1'b0;
					next_r.st = ASRPH_START;
					next_r.cnt = 5'h0;
					next_r.nbits = 5'h12;
					// Address byte, ack slot, then one byte and ack slot; a write sends a second byte and ack slot
					if (r.ctrl[ASRP_HC_READ]) begin
						next_r.seq = {ASRP_SLAVE_ADDR, 1'b1, 1'b1,
							8'hFF, 1'b1, 9'h000}; // Nack ends read
						next_r.rdmask = {8'h00, 1'b1, 8'hFF, 1'b0, 9'h000};
					end else if (r.ctrl[ASRP_HC_SETPTR]) begin
						next_r.seq = {ASRP_SLAVE_ADDR, 1'b0, 1'b1,
							r.addr, 1'b1, 9'h000};
						next_r.rdmask = {8'h00, 1'b1, 8'h00, 1'b1, 9'h000};
					end else begin
						next_r.nbits = 5'h1B;
						next_r.seq = {ASRP_SLAVE_ADDR, 1'b0, 1'b1,
							r.addr, 1'b1, r.wdata, 1'b1};
						next_r.rdmask = {8'h00, 1'b1, 8'h00, 1'b1,
							8'h00, 1'b1};
					end
				end
			end
			ASRPH_START: begin
				// Data falls while clock high
				next_r.sda = 1'b0;
				next_r.cnt = r.cnt + 5'h1;
				if (r.cnt == 5'(ASRP_HALF_CYC - 1)) begin
					next_r.scl = 1'b0;
					next_r.cnt = 5'h0;
					next_r.phase = 6'h0;
					next_r.st = ASRPH_BIT;
				end
			end
			ASRPH_BIT: begin
				next_r.cnt = r.cnt + 5'h1;
				if (r.cnt == 5'(ASRP_HALF_CYC - 1)) begin
					next_r.cnt = 5'h0;
					next_r.phase = r.phase + 6'h1;
					if (!r.phase[0]) begin
						next_r.scl = 1'b1;
					end else begin
						next_r.scl = 1'b0;
						next_r.seq = {r.seq[25:0], 1'b1};
						next_r.rdmask = {r.rdmask[25:0], 1'b0};
						if (r.phase[5:1] == r.nbits - 5'h1) begin
							next_r.st = ASRPH_STOP;
							next_r.sda = 1'b0;
						end
					end
				end else if (r.cnt == 5'h2 && !r.phase[0]) begin
					// Data set two cycles into the low phase, sampled mid high phase
					next_r.sda = r.seq[26];
				end else if (r.cnt == 5'(ASRP_HALF_CYC / 2) && r.phase[0]
					&& r.rdmask[26]) begin
					if (r.phase[5:1] == 5'h08 || r.phase[5:1] == 5'h11
						|| r.phase[5:1] == 5'h1A) begin
						next_r.nack = r.nack | r.sda_s[1];
					end else begin
						next_r.rbyte = {r.rbyte[6:0], r.sda_s[1]};
					end
				end
			end
			ASRPH_STOP: begin
				next_r.cnt = r.cnt + 5'h1;
				if (r.cnt == 5'(ASRP_HALF_CYC - 1)) begin
					next_r.scl = 1'b1;
				end
				if (r.cnt == 5'h1F) begin
					next_r.sda = 1'b1;
					next_r.busy = 1'b0;
					next_r.st = ASRPH_IDLE;
				end
			end
			default: next_r.st = ASRPH_IDLE;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			r <= '0;
			r.sda_s <= 2'h3;
			r.scl <= 1'b1;
			r.sda <= 1'b1;
			r.st <= ASRPH_IDLE;
		end else begin
			r <= next_r;
		end
	end

	assign bus.scl_o = 1'b0;
	assign bus.scl_oe = ~r.scl;
	assign bus.sda_host_o = 1'b0;
	assign bus.sda_host_oe = ~r.sda;
	assign wb_dat_o = r.dout;
	assign wb_ack_o = r.ack;
endmodule

// ===== asrp_sva.sv
`timescale 1ns/1ps
module asrp_sva (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic scl_o,
	input wire logic scl_oe,
	input wire logic sda_dev_o,
	input wire logic sda_dev_oe,
	input wire logic sda_host_o,
	input wire logic sda_host_oe,
	input wire logic scl,
	input wire logic sda
);
	localparam int LOW_MIN = 20;
	logic [9:0] lo_cnt;
	logic [9:0] hi_cnt;
	logic [9:0] dv_cnt;
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	////////////////////////////////////////////////////////////////////////
	// Saturating run lengths, so a long idle cannot wrap to zero
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			lo_cnt <= 10'h000;
			hi_cnt <= 10'h000;
			dv_cnt <= 10'h000;
		end else begin
			lo_cnt <= !scl_oe ? 10'h000 : lo_cnt + {9'h000, ~&lo_cnt};
			hi_cnt <= scl_oe ? 10'h000 : hi_cnt + {9'h000, ~&hi_cnt};
			dv_cnt <= !sda_dev_oe ? 10'h000 : dv_cnt + {9'h000, ~&dv_cnt};
		end
	end
	////////////////////////////////////////////////////////////////////////
	// Open-drain lines only ever pull low
	a_lines_only_pull: assert property (!scl_o && !sda_dev_o && !sda_host_o)
		else $error("a serial line was driven high");
	a_dev_quiet_reset: assert property ($fell(rst_i) |-> !sda_dev_oe)
		else $error("device drives data right after reset");
	a_dev_stable_high: assert property (scl && $past(scl) |-> $stable(sda_dev_oe))
		else $error("device changed data while clock high");
	a_dev_change_low: assert property ($changed(sda_dev_oe) |-> !scl && !$past(scl, 2))
		else $error("device changed data too close to a clock edge");
	a_start_dev_idle: assert property (scl && $past(scl) && $fell(sda) |-> !sda_dev_oe)
		else $error("device still driving at a start");
	// Host low phase must outlast the input filter
	a_scl_low_min: assert property ($fell(scl_oe) |-> lo_cnt >= LOW_MIN)
		else $error("clock low phase too short");
	a_scl_low_max: assert property (scl_oe |-> lo_cnt < 10'h0C8)
		else $error("clock held low too long");
	a_dev_pull_bound: assert property (sda_dev_oe |-> dv_cnt < 10'h1F4)
		else $error("device pulled data longer than one byte");
	a_idle_release: assert property (hi_cnt > 10'h03C |-> !sda_dev_oe)
		else $error("device drives an idle bus");
	c_start: cover property (scl && $fell(sda));
	c_dev_ack: cover property ($rose(sda_dev_oe));
	c_dev_release: cover property ($fell(sda_dev_oe) && !scl);
endmodule

// ===== angle_sensor_register_port_tb.sv
`timescale 1ns/1ps
module angle_sensor_register_port_tb;
	import asrp_pkg::*;
	localparam logic [2:0] OP_SET = 3'h5;
	localparam logic [2:0] OP_RD = 3'h3;
	localparam logic [2:0] OP_WR = 3'h1;
	logic clk_i = 1'h0;
	logic rst_i = 1'h1;
	logic wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0, wb_ack_o;
	logic [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
	logic [11:0] unscaled_angle_i = 12'hC71, angle_i = 12'h9C3;
	logic [11:0] magnitude_i = 12'h5E2, nv_start_i = 12'h123;
	logic [11:0] nv_stop_i = 12'h456, nv_span_i = 12'h789;
	logic [7:0] gain_i = 8'hB4;
	logic [2:0] magnet_i = 3'h5;
	logic [1:0] nv_burn_count_i = 2'h2;
	logic [13:0] nv_config_i = 14'h2A5C;
	logic [1:0] power_mode_sel_o, output_hysteresis_o, output_stage_sel_o;
	logic [1:0] pulse_freq_sel_o, slow_filter_sel_o;
	logic [2:0] fast_filter_threshold_o;
	logic watchdog_enable_o, burn_angle_o, burn_setting_o;
	logic [11:0] start_position_o, stop_position_o, span_setting_o;
	int error_cnt = 0, total_checks = 0, cycle_cnt = 0, n_ba = 0, n_bs = 0;
	asrp_if bus1 ();
	asrp_if bus2 ();
	////////////////////////////////////////////////////////////////////////
	asrp_device asrp_device_inst (.clk_i, .rst_i, .bus(bus1.device),
		.unscaled_angle_i, .angle_i, .magnitude_i, .gain_i, .magnet_i,
		.nv_burn_count_i, .nv_start_i, .nv_stop_i, .nv_span_i, .nv_config_i,
		.power_mode_sel_o, .output_hysteresis_o, .output_stage_sel_o,
		.pulse_freq_sel_o, .slow_filter_sel_o, .fast_filter_threshold_o,
		.watchdog_enable_o, .start_position_o, .stop_position_o,
		.span_setting_o, .burn_angle_o, .burn_setting_o);
	// Second device faces the bench's own rule-breaking bit driver
	asrp_device asrp_device_inst2 (.clk_i, .rst_i, .bus(bus2.device),
		.unscaled_angle_i, .angle_i, .magnitude_i, .gain_i, .magnet_i,
		.nv_burn_count_i, .nv_start_i, .nv_stop_i, .nv_span_i, .nv_config_i,
		.power_mode_sel_o(), .output_hysteresis_o(), .output_stage_sel_o(),
		.pulse_freq_sel_o(), .slow_filter_sel_o(), .fast_filter_threshold_o(),
		.watchdog_enable_o(), .start_position_o(), .stop_position_o(),
		.span_setting_o(), .burn_angle_o(), .burn_setting_o());
	asrp_host asrp_host_inst (.clk_i, .rst_i, .bus(bus1.host), .wb_cyc_i,
		.wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
		.wb_ack_o);
	asrp_sva asrp_sva_inst (.clk_i, .rst_i, .scl_o(bus1.scl_o),
		.scl_oe(bus1.scl_oe), .sda_dev_o(bus1.sda_dev_o),
		.sda_dev_oe(bus1.sda_dev_oe), .sda_host_o(bus1.sda_host_o),
		.sda_host_oe(bus1.sda_host_oe), .scl(bus1.scl), .sda(bus1.sda));
	////////////////////////////////////////////////////////////////////////
	always #2.5 clk_i = ~clk_i;
	initial begin
		bus2.scl_o = 1'h0;
		bus2.sda_host_o = 1'h0;
		bus2.scl_oe = 1'h0;
		bus2.sda_host_oe = 1'h0;
	end
	// Burn pulse counting and hang guard
	always @(posedge clk_i) begin
		cycle_cnt++;
		if (burn_angle_o === 1'h1) n_ba++;
		if (burn_setting_o === 1'h1) n_bs++;
		if (cycle_cnt == 90000) begin
			error_cnt++;
			$display("[ERR] run length expected below %0d seen %0d", 90000, cycle_cnt);
			give_verdict();
		end
	end
	////////////////////////////////////////////////////////////////////////
	task give_verdict();
		$display("checks %0d mismatches %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		total_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task wt(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	function automatic logic [15:0] cfg_out();
		return {2'h0, watchdog_enable_o, fast_filter_threshold_o,
			slow_filter_sel_o, pulse_freq_sel_o, output_stage_sel_o,
			output_hysteresis_o, power_mode_sel_o};
	endfunction
	// Classic single Wishbone cycle; only the run timeout ends the wait
	task wb(input logic we, input logic [3:0] adr, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge clk_i);
		wb_cyc_i <= 1'h1;
		wb_stb_i <= 1'h1;
		wb_we_i <= we;
		wb_adr_i <= adr;
		wb_sel_i <= 4'h1;
		wb_dat_i <= d;
		do begin
			@(posedge clk_i);
		end while (wb_ack_o !== 1'h1);
		q = wb_dat_o;
		wb_cyc_i <= 1'h0;
		wb_stb_i <= 1'h0;
	endtask
	// One serial transaction through the host, polled until idle
	task op(input logic [2:0] ctl, input logic [7:0] ptr, input logic [7:0] d,
		output logic [7:0] rb);
		logic [31:0] q;
		wb(1'h1, ASRP_H_ADDR, {24'h0, ptr}, q);
		wb(1'h0, ASRP_H_ADDR, 32'h0, q);
		chk("host pointer reg", {8'h0, ptr}, q[15:0]);
		wb(1'h1, ASRP_H_WDATA, {24'h0, d}, q);
		wb(1'h1, ASRP_H_CTRL, {29'h0, ctl}, q);
		do wb(1'h0, ASRP_H_STATUS, 32'h0, q); while (q[8] !== 1'h0);
		chk("device ack", 16'h0, {15'h0, q[9]});
		rb = q[7:0];
	endtask
	task rd2(input logic [7:0] a, input logic [7:0] e1, input logic [7:0] e2);
		logic [7:0] rb;
		op(OP_SET, a, 8'h00, rb);
		op(OP_RD, 8'h00, 8'h00, rb);
		chk("first read", {8'h0, e1}, {8'h0, rb});
		op(OP_RD, 8'h00, 8'h00, rb);
		chk("second read", {8'h0, e2}, {8'h0, rb});
	endtask
	// Bit driver on the second link; optional sub-50 ns spikes
	task bb_xfer(input logic [8:0] tx, input logic gl, output logic [8:0] rx);
		for (int i = 8; i >= 0; i--) begin
			wt(5);
			bus2.sda_host_oe <= ~tx[i];
			wt(20);
			bus2.scl_oe <= 1'h0;
			wt(3);
			bus2.scl_oe <= gl;
			wt(8);
			bus2.scl_oe <= 1'h0;
			wt(3);
			bus2.sda_host_oe <= ~tx[i] ^ gl;
			wt(8);
			bus2.sda_host_oe <= ~tx[i];
			wt(3);
			rx[i] = bus2.sda;
			bus2.scl_oe <= 1'h1;
		end
	endtask
	task bb_start();
		wt(1);
		bus2.sda_host_oe <= 1'h1;
		wt(25);
		bus2.scl_oe <= 1'h1;
	endtask
	task bb_stop();
		wt(5);
		bus2.sda_host_oe <= 1'h1;
		wt(20);
		bus2.scl_oe <= 1'h0;
		wt(25);
		bus2.sda_host_oe <= 1'h0;
		wt(25);
	endtask
	////////////////////////////////////////////////////////////////////////
	task t_reset_load();
		chk("config fields", {2'h0, nv_config_i}, cfg_out());
		chk("start", {4'h0, nv_start_i}, {4'h0, start_position_o});
		chk("stop", {4'h0, nv_stop_i}, {4'h0, stop_position_o});
		chk("span", {4'h0, nv_span_i}, {4'h0, span_setting_o});
		rd2(ASRP_A_CONFIG_HI, {2'h0, nv_config_i[13:8]}, nv_config_i[7:0]);
		rd2(ASRP_A_BURN_COUNT, {6'h0, nv_burn_count_i}, {4'h0, nv_start_i[11:8]});
		$display("test reset_load done");
	endtask
	task t_config_codes();
		logic [13:0] c;
		logic [7:0] rb;
		for (int i = 0; i < 8; i++) begin
			c = {i[0], i[2:0], i[1:0], i[1:0], i[1:0], i[1:0], i[1:0]};
			op(OP_WR, ASRP_A_CONFIG_HI, {2'h0, c[13:8]}, rb);
			op(OP_WR, ASRP_A_CONFIG_LO, c[7:0], rb);
			wt(4);
			chk("config fields", {2'h0, c}, cfg_out());
		end
		// Whole word read back, as read-modify-write needs
		rd2(ASRP_A_CONFIG_HI, {2'h0, c[13:8]}, c[7:0]);
		$display("test config_codes done");
	endtask
	task t_positions();
		logic [7:0] rb;
		logic [7:0] hi;
		for (int k = 0; k < 3; k++) begin
			// Nibbles 0, 4, 8: range stays far above 18 degrees
			hi = 8'hF0 + 8'(4 * k);
			op(OP_WR, ASRP_A_START_HI + 8'(2 * k), hi, rb);
			op(OP_WR, ASRP_A_START_LO + 8'(2 * k), 8'h5C, rb);
		end
		wt(4);
		chk("start", 16'h005C, {4'h0, start_position_o});
		chk("stop", 16'h045C, {4'h0, stop_position_o});
		chk("span", 16'h085C, {4'h0, span_setting_o});
		rd2(ASRP_A_STOP_HI, 8'h04, 8'h5C);
		$display("test positions done");
	endtask
	task t_outputs();
		logic [7:0] rb;
		rd2(ASRP_A_ANGLE_HI, {4'h0, angle_i[11:8]}, {4'h0, angle_i[11:8]});
		rd2(ASRP_A_UNSCALED_LO, unscaled_angle_i[7:0], {4'h0, angle_i[11:8]});
		rd2(ASRP_A_MAG_HI, {4'h0, magnitude_i[11:8]}, {4'h0, magnitude_i[11:8]});
		rd2(ASRP_A_STATUS, {2'h0, magnet_i, 3'h0}, {4'h0, unscaled_angle_i[11:8]});
		rd2(8'h19, 8'h00, gain_i);
		rd2(8'hFE, 8'h00, 8'h00);
		op(OP_RD, 8'h00, 8'h00, rb);
		chk("wrapped read", {14'h0, nv_burn_count_i}, {8'h0, rb});
		op(OP_WR, ASRP_A_ANGLE_HI, 8'h55, rb);
		rd2(ASRP_A_ANGLE_HI, {4'h0, angle_i[11:8]}, {4'h0, angle_i[11:8]});
		$display("test outputs done");
	endtask
	task t_burn();
		logic [7:0] rb;
		n_ba = 0;
		n_bs = 0;
		op(OP_WR, ASRP_A_BURN_CMD, 8'h11, rb);
		wt(4);
		chk("burn pulses", 16'h0000, {8'(n_ba), 8'(n_bs)});
		op(OP_WR, ASRP_A_BURN_CMD, ASRP_CMD_BURN_ANGLE, rb);
		wt(4);
		chk("burn pulses", 16'h0100, {8'(n_ba), 8'(n_bs)});
		op(OP_WR, ASRP_A_BURN_CMD, ASRP_CMD_BURN_SETTING, rb);
		wt(4);
		chk("burn pulses", 16'h0101, {8'(n_ba), 8'(n_bs)});
		$display("test burn done");
	endtask
	task t_link_faults();
		logic [8:0] rx;
		bb_start();
		bb_xfer({ASRP_SLAVE_ADDR ^ 7'h01, 1'h0, 1'h1}, 1'h0, rx);
		bb_stop();
		chk("foreign address ack", 16'h0001, {15'h0, rx[0]});
		bb_start();
		bb_xfer({ASRP_SLAVE_ADDR, 1'h0, 1'h1}, 1'h1, rx);
		chk("spiked address ack", 16'h0000, {15'h0, rx[0]});
		bb_xfer({ASRP_A_ANGLE_HI, 1'h1}, 1'h1, rx);
		bb_stop();
		bb_start();
		bb_xfer({ASRP_SLAVE_ADDR, 1'h1, 1'h1}, 1'h0, rx);
		chk("read address ack", 16'h0000, {15'h0, rx[0]});
		bb_xfer({8'hFF, 1'h0}, 1'h0, rx);
		chk("acked byte", {12'h0, angle_i[11:8]}, {8'h0, rx[8:1]});
		bb_xfer({8'hFF, 1'h1}, 1'h0, rx);
		chk("last byte", {12'h0, angle_i[11:8]}, {8'h0, rx[8:1]});
		bb_stop();
		$display("test link_faults done");
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		wt(20);
		rst_i <= 1'h0;
		wt(3);
		t_reset_load();
		t_config_codes();
		t_positions();
		t_outputs();
		t_burn();
		t_link_faults();
		give_verdict();
	end
endmodule
